// ---- dspcmg_pkg.sv ----
// constants, field layouts and types of the clock mode generator
// assumes a single 200 MHz system clock and an apb register port
`default_nettype none
package dspcmg_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ        = 200_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = 5;
  localparam int unsigned LOCK_TIME_MS    = 30;
  localparam int unsigned LOCK_CYCLES     = (CLOCK_HZ / 1000) * LOCK_TIME_MS;
  localparam int unsigned REF_MIN_NS      = 20;
  localparam int unsigned REF_MAX_INT_NS  = 200;
  localparam int unsigned REF_MAX_HALF_NS = 100;
  localparam int unsigned REF_MAX_QTR_NS  = 50;
  // least time rounds up, longest time rounds down
  localparam logic [7:0] REF_MIN_CYC      = 8'((REF_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [7:0] REF_MAX_INT_CYC  = 8'(REF_MAX_INT_NS / CLOCK_PERIOD_NS);
  localparam logic [7:0] REF_MAX_HALF_CYC = 8'(REF_MAX_HALF_NS / CLOCK_PERIOD_NS);
  localparam logic [7:0] REF_MAX_QTR_CYC  = 8'(REF_MAX_QTR_NS / CLOCK_PERIOD_NS);
  localparam logic [7:0] PERIOD_SAT       = 8'hff;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PLL_MODE    = 8'h00;
  localparam logic [7:0] ADDR_BANK_SWITCH = 8'h04;
  localparam int unsigned MULT_LSB        = 0;
  localparam int unsigned PLL_ON_BIT      = 8;
  localparam int unsigned LOCKED_BIT      = 9;
  localparam int unsigned FAULT_BIT       = 10;
  localparam int unsigned STRAP_LSB       = 12;
  localparam int unsigned DIV_LSB         = 0;
  localparam logic [5:0] MULT_ZERO        = 6'h00;
  localparam logic [5:0] MULT_ONE         = 6'h04;
  localparam logic [1:0] FRAC_INT         = 2'h0;
  localparam logic [1:0] FRAC_HALF        = 2'h2;
  localparam logic [1:0] DIV_NONE         = 2'h0;
  localparam logic [1:0] DIV_RESET        = 2'h3;
  localparam logic [2:0] STRAP_DIV2_LO    = 3'h0;
  localparam logic [2:0] STRAP_DIV4       = 3'h5;
  localparam logic [2:0] STRAP_DIV2_HI    = 3'h7;
  localparam logic [2:0] STRAP_OSC        = 3'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_DIV2 = 2'b00,
    MODE_DIV4 = 2'b01,
    MODE_PLL  = 2'b10
  } dspcmg_mode_t;

  typedef enum logic
  {
    ST_RUN  = 1'b0,
    ST_LOCK = 1'b1
  } dspcmg_lock_t;

endpackage
`default_nettype wire

// ---- dspcmg_clk_if.sv ----
// link between the control top and the machine tick generator
// assumes both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface dspcmg_clk_if;
  dspcmg_pkg::dspcmg_mode_t mode;      // active clock mode
  logic [5:0]               mult_q;    // multiplier in quarters
  logic                     ref_level; // reference clock level
  logic                     tick;      // machine clock half-period pulse
  logic [7:0]               period;    // measured reference period, cycles

  modport gen
  (
    input  mode,
    input  mult_q,
    input  ref_level,
    output tick,
    output period
  );
  modport ctl
  (
    output mode,
    output mult_q,
    output ref_level,
    input  tick,
    input  period
  );
endinterface
`default_nettype wire

// ---- dspcmg_tick_gen.sv ----
// machine clock tick generator: divide or digitally multiply the reference
// assumes the reference level is synchronous to the system clock
`timescale 1ns/10ps
`default_nettype none
module dspcmg_tick_gen
(
  input  wire logic   clock, // system clock
  input  wire logic   reset, // synchronous, active high
  dspcmg_clk_if.gen   link   // mode in, ticks out
);

  typedef struct packed
  {
    logic        ref_q;
    logic [7:0]  cnt;
    logic [7:0]  period;
    logic        div_ph;
    logic [10:0] acc;
    logic        tick;
  } dspcmg_gen_state_t;

  dspcmg_gen_state_t cur;
  dspcmg_gen_state_t next_cur;

  // ---------------------------------------------------------------
  // period measure and tick generation
  // ---------------------------------------------------------------
  // the phase accumulator spreads 2*N ticks over each measured
  // reference period; jitter of one system cycle is the price
  always_comb
  begin
    logic        rise;
    logic [10:0] lim;
    logic [10:0] sum;
    rise = 1'b0;
    lim = 11'h000;
    sum = 11'h000;
    next_cur = cur;
    rise = link.ref_level & ~cur.ref_q;
    next_cur.ref_q = link.ref_level;
    next_cur.tick = 1'b0;
    if (rise)
    begin
      next_cur.period = cur.cnt;
      next_cur.cnt = 8'h01;
    end
    else if (cur.cnt != dspcmg_pkg::PERIOD_SAT)
    begin
      next_cur.cnt = cur.cnt + 8'h01;
    end
    lim = {1'b0, cur.period, 2'b00};
    sum = cur.acc + {4'h0, link.mult_q, 1'b0};
    case (link.mode)
      dspcmg_pkg::MODE_DIV2:
      begin
        next_cur.tick = rise;
        next_cur.acc = 11'h000;
      end
      dspcmg_pkg::MODE_DIV4:
      begin
        if (rise)
        begin
          next_cur.div_ph = ~cur.div_ph;
          next_cur.tick = cur.div_ph;
        end
        next_cur.acc = 11'h000;
      end
      dspcmg_pkg::MODE_PLL:
      begin
        if (lim != 11'h000)
        begin
          next_cur.acc = sum;
          if (sum >= lim)
          begin
            next_cur.tick = 1'b1;
            // overspeed clamp keeps the accumulator bounded
            next_cur.acc = ((sum - lim) >= lim) ? 11'h000 : (sum - lim);
          end
        end
      end
      default:
      begin
        next_cur.acc = 11'h000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cur       <= '0;
      // follow the free running pin so a level already high is no rise
      cur.ref_q <= link.ref_level;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign link.tick   = cur.tick;
  assign link.period = cur.period;

endmodule
`default_nettype wire

// ---- dspcmg_top.sv ----
// clock mode generator: strap decode, pll mode register, output divider
// assumes apb master on the system clock and straps stable during reset
`timescale 1ns/10ps
`default_nettype none
module dspcmg_top
#(
  parameter int unsigned LOCK_CYCLES = dspcmg_pkg::LOCK_CYCLES // pll lock wait
)
(
  input  wire logic        clock,                 // 200 MHz system clock
  input  wire logic        reset,                 // synchronous, active high
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb write
  input  wire logic [7:0]  paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output var  logic [31:0] prdata,                // apb read data
  output var  logic        pready,                // apb ready
  output var  logic        pslverr,               // apb error, unmapped
  input  wire logic        clock_mode_strap_1,    // mode strap 1
  input  wire logic        clock_mode_strap_2,    // mode strap 2
  input  wire logic        clock_mode_strap_3,    // mode strap 3
  input  wire logic        reference_clock_input, // reference clock level
  output var  logic        oscillator_enable,     // internal oscillator on
  output var  logic        machine_clock,         // machine clock level
  output var  logic        machine_tick,          // machine clock edge pulse
  output var  logic        machine_clock_output,  // divided output clock
  output var  logic        pll_locked             // multiplied clock stable
);

  typedef struct packed
  {
    dspcmg_pkg::dspcmg_lock_t lock;
    logic [2:0]               strap;
    logic [5:0]               mult_cur;
    logic [5:0]               mult_pend;
    logic                     pll_on;
    logic                     pend_on;
    logic [31:0]              lock_cnt;
    logic                     locked;
    logic                     fault;
    logic [1:0]               div_field;
    logic                     mclk;
    logic                     tick;
    logic [1:0]               out_cnt;
    logic                     out_clk;
    logic                     osc_en;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } dspcmg_top_state_t;

  dspcmg_top_state_t cur;
  dspcmg_top_state_t next_cur;
  dspcmg_clk_if      clk_link ();

  // ---------------------------------------------------------------
  // tick generator
  // ---------------------------------------------------------------
  dspcmg_tick_gen u_tick_gen
  (
    .clock (clock),
    .reset (reset),
    .link  (clk_link.gen)
  );

  // applied configuration steers the generator; a pending one waits
  // out the lock time so the machine clock never sees a half setting
  always_comb
  begin
    if (cur.pll_on)
    begin
      clk_link.mode = dspcmg_pkg::MODE_PLL;
    end
    else if (cur.strap == dspcmg_pkg::STRAP_DIV4)
    begin
      clk_link.mode = dspcmg_pkg::MODE_DIV4;
    end
    else
    begin
      clk_link.mode = dspcmg_pkg::MODE_DIV2;
    end
  end
  assign clk_link.mult_q    = cur.mult_cur;
  assign clk_link.ref_level = reference_clock_input;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [2:0]  strap_in;
    logic        strap_pll;
    logic        hit_pll;
    logic        hit_bank;
    logic        done;
    logic [7:0]  max_cyc;
    logic [31:0] rd;
    strap_in  = {clock_mode_strap_1, clock_mode_strap_2, clock_mode_strap_3};
    strap_pll = 1'b0;
    hit_pll   = 1'b0;
    hit_bank  = 1'b0;
    done      = 1'b0;
    max_cyc   = dspcmg_pkg::REF_MAX_INT_CYC;
    rd        = 32'h0000_0000;
    next_cur  = cur;

    // straps outside the divide table start the pll at times one
    strap_pll = (strap_in != dspcmg_pkg::STRAP_DIV2_LO) &&
                (strap_in != dspcmg_pkg::STRAP_DIV4) &&
                (strap_in != dspcmg_pkg::STRAP_DIV2_HI);

    if (reset)
    begin
      next_cur           = '0;
      next_cur.strap     = strap_in;
      next_cur.osc_en    = (strap_in == dspcmg_pkg::STRAP_OSC);
      next_cur.mult_cur  = dspcmg_pkg::MULT_ONE;
      next_cur.mult_pend = dspcmg_pkg::MULT_ONE;
      next_cur.pll_on    = 1'b0;
      next_cur.pend_on   = strap_pll;
      next_cur.lock      = strap_pll ? dspcmg_pkg::ST_LOCK : dspcmg_pkg::ST_RUN;
      next_cur.locked    = ~strap_pll;
      next_cur.div_field = dspcmg_pkg::DIV_RESET;
    end
    else
    begin
      // pll lock wait
      case (cur.lock)
        dspcmg_pkg::ST_RUN:
        begin
          next_cur.lock_cnt = 32'h0000_0000;
        end
        dspcmg_pkg::ST_LOCK:
        begin
          next_cur.lock_cnt = cur.lock_cnt + 32'h0000_0001;
          if (cur.lock_cnt >= 32'(LOCK_CYCLES - 1))
          begin
            next_cur.lock     = dspcmg_pkg::ST_RUN;
            next_cur.mult_cur = cur.mult_pend;
            next_cur.pll_on   = cur.pend_on;
            next_cur.locked   = 1'b1;
            next_cur.lock_cnt = 32'h0000_0000;
          end
        end
        default:
        begin
          next_cur.lock = dspcmg_pkg::ST_RUN;
        end
      endcase

      // input period against the range of the multiplier class
      case (cur.mult_cur[1:0])
        dspcmg_pkg::FRAC_INT:  max_cyc = dspcmg_pkg::REF_MAX_INT_CYC;
        dspcmg_pkg::FRAC_HALF: max_cyc = dspcmg_pkg::REF_MAX_HALF_CYC;
        default:               max_cyc = dspcmg_pkg::REF_MAX_QTR_CYC;
      endcase
      next_cur.fault = cur.pll_on &&
                       ((clk_link.period < dspcmg_pkg::REF_MIN_CYC) ||
                        (clk_link.period > max_cyc));

      // machine clock and output divider; divide by field plus one
      next_cur.tick = clk_link.tick;
      if (clk_link.tick)
      begin
        next_cur.mclk = ~cur.mclk;
        if (cur.div_field == dspcmg_pkg::DIV_NONE)
        begin
          next_cur.out_clk = ~cur.mclk;
          next_cur.out_cnt = 2'h0;
        end
        else if (cur.out_cnt >= cur.div_field)
        begin
          next_cur.out_clk = ~cur.out_clk;
          next_cur.out_cnt = 2'h0;
        end
        else
        begin
          next_cur.out_cnt = cur.out_cnt + 2'h1;
        end
      end

      // apb slave: one wait state, write lands at the completing edge
      hit_pll  = (paddr == dspcmg_pkg::ADDR_PLL_MODE);
      hit_bank = (paddr == dspcmg_pkg::ADDR_BANK_SWITCH);
      done     = psel & penable & cur.pready;
      next_cur.pready = psel & penable & ~cur.pready;
      rd[dspcmg_pkg::MULT_LSB +: 6]  = cur.mult_cur;
      rd[dspcmg_pkg::PLL_ON_BIT]     = cur.pll_on;
      rd[dspcmg_pkg::LOCKED_BIT]     = cur.locked;
      rd[dspcmg_pkg::FAULT_BIT]      = cur.fault;
      rd[dspcmg_pkg::STRAP_LSB +: 3] = cur.strap;
      if (hit_bank)
      begin
        rd = 32'h0000_0000;
        rd[dspcmg_pkg::DIV_LSB +: 2] = cur.div_field;
      end
      else if (!hit_pll)
      begin
        rd = 32'h0000_0000;
      end
      next_cur.prdata  = (psel & penable & ~cur.pready & ~pwrite) ? rd : 32'h0000_0000;
      next_cur.pslverr = psel & penable & ~cur.pready & ~hit_pll & ~hit_bank;

      if (done && pwrite && hit_pll &&
          (pwdata[dspcmg_pkg::MULT_LSB +: 6] != dspcmg_pkg::MULT_ZERO))
      begin
        // a new factor restarts the lock wait; the old one keeps running
        next_cur.mult_pend = pwdata[dspcmg_pkg::MULT_LSB +: 6];
        next_cur.pend_on   = pwdata[dspcmg_pkg::PLL_ON_BIT];
        next_cur.lock      = dspcmg_pkg::ST_LOCK;
        next_cur.lock_cnt  = 32'h0000_0000;
        next_cur.locked    = 1'b0;
      end
      if (done && pwrite && hit_bank)
      begin
        next_cur.div_field = pwdata[dspcmg_pkg::DIV_LSB +: 2];
        next_cur.out_cnt   = 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    cur <= next_cur;
  end

  assign prdata               = cur.prdata;
  assign pready               = cur.pready;
  assign pslverr              = cur.pslverr;
  assign oscillator_enable    = cur.osc_en;
  assign machine_clock        = cur.mclk;
  assign machine_tick         = cur.tick;
  assign machine_clock_output = cur.out_clk;
  assign pll_locked           = cur.locked;

endmodule
`default_nettype wire

// ---- dspcmg_monitor.sv ----
// port checker of the clock mode generator
// assumes it is bound to dspcmg_top and shares its clock and reset
`timescale 1ns/10ps
`default_nettype none
module dspcmg_monitor
#(
  parameter int unsigned LOCK_CYCLES = dspcmg_pkg::LOCK_CYCLES // lock wait in cycles
)
(
  input wire logic        clock,                // system clock
  input wire logic        reset,                // sync reset
  input wire logic        psel,                 // apb select
  input wire logic        penable,              // apb access
  input wire logic        pwrite,               // apb write
  input wire logic [7:0]  paddr,                // apb address
  input wire logic [31:0] pwdata,               // apb write data
  input wire logic [31:0] prdata,               // apb read data
  input wire logic        pready,               // apb ready
  input wire logic        pslverr,              // apb error
  input wire logic        clock_mode_strap_1,   // strap 1
  input wire logic        clock_mode_strap_2,   // strap 2
  input wire logic        clock_mode_strap_3,   // strap 3
  input wire logic        oscillator_enable,    // oscillator on
  input wire logic        machine_clock,        // machine clock
  input wire logic        machine_tick,         // machine tick
  input wire logic        machine_clock_output, // output clock
  input wire logic        pll_locked            // lock flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // -----------------------------------------------------------
  // helper state
  // -----------------------------------------------------------
  logic        hs;    // completed transfer
  logic [1:0]  div;   // shadow of divide field
  logic [3:0]  tcnt;  // ticks since output edge
  logic        armed; // a whole output half seen
  int unsigned lcnt;  // cycles spent unlocked
  assign hs = psel && penable && pready;
  // shadow follows writes; armed waits one edge so a divider change settles first
  always_ff @(posedge clock)
  begin
    if (reset || (hs && pwrite && paddr == dspcmg_pkg::ADDR_BANK_SWITCH))
      armed <= 1'b0;
    else if (machine_clock_output != $past(machine_clock_output))
      armed <= 1'b1;
    if (reset)
      div <= dspcmg_pkg::DIV_RESET;
    else if (hs && pwrite && paddr == dspcmg_pkg::ADDR_BANK_SWITCH)
      div <= pwdata[1:0];
    if (reset || machine_clock_output != $past(machine_clock_output))
      tcnt <= 4'h0;
    else
      tcnt <= tcnt + 4'(machine_tick);
    if (reset || pll_locked || (hs && pwrite && paddr == dspcmg_pkg::ADDR_PLL_MODE && pwdata[5:0] != 6'h00))
      lcnt <= 0;
    else
      lcnt <= lcnt + 1;
  end
  // -----------------------------------------------------------
  // properties
  // -----------------------------------------------------------
  property p_osc_reset;
    $fell(reset) |-> oscillator_enable == ($past({clock_mode_strap_1, clock_mode_strap_2, clock_mode_strap_3}) == 3'h0);
  endproperty
  a_osc_reset: assert property (p_osc_reset) else $error("oscillator enable wrong after reset");
  property p_osc_hold;
    !$past(reset) |-> $stable(oscillator_enable);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator enable moved");
  property p_rdy;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after access");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than a cycle");
  property p_err;
    pready |-> pslverr == !(paddr == dspcmg_pkg::ADDR_PLL_MODE || paddr == dspcmg_pkg::ADDR_BANK_SWITCH);
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_err_data;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("data on refused read");
  property p_lock_drop;
    hs && pwrite && paddr == dspcmg_pkg::ADDR_PLL_MODE && pwdata[5:0] != 6'h00 |-> ##[1:2] !pll_locked;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept after new multiplier");
  property p_lock_max;
    lcnt <= LOCK_CYCLES + 3;
  endproperty
  a_lock_max: assert property (p_lock_max) else $error("lock wait too long");
  property p_div_period;
    $changed(machine_clock_output) && armed |-> tcnt + 4'(machine_tick) == {2'h0, div} + 4'h1;
  endproperty
  a_div_period: assert property (p_div_period) else $error("output half period wrong");
  property p_tick_clk;
    machine_tick |-> ##[0:1] $changed(machine_clock);
  endproperty
  a_tick_clk: assert property (p_tick_clk) else $error("machine clock missed a tick");
  c_wait: cover property ($rose(pll_locked));
  c_err: cover property (pready && pslverr);
  c_copy: cover property ($changed(machine_clock_output) && armed && div == 2'h0);
endmodule
bind dspcmg_top dspcmg_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) mon
(
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clock_mode_strap_1(clock_mode_strap_1), .clock_mode_strap_2(clock_mode_strap_2),
  .clock_mode_strap_3(clock_mode_strap_3), .oscillator_enable(oscillator_enable),
  .machine_clock(machine_clock), .machine_tick(machine_tick),
  .machine_clock_output(machine_clock_output), .pll_locked(pll_locked)
);
`default_nettype wire

// ---- dspcmg_ref_src.sv ----
// reference clock source model for the clock mode generator
// assumes the bench sets the half period in system clock cycles
`timescale 1ns/10ps
`default_nettype none
module dspcmg_ref_src
(
  input  wire logic       clock,    // system clock
  input  wire logic [7:0] half,     // half period in cycles
  output var  logic       ref_level // reference clock level
);
  logic [7:0] cnt = 8'h00; // cycles in this half
  // a crystal runs free, so there is no idle level to hold
  initial
    ref_level = 1'b0;
  always @(posedge clock)
  begin
    if (cnt + 8'h01 >= half)
    begin
      cnt <= 8'h00;
      ref_level <= ~ref_level;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule
`default_nettype wire

// ---- test_dsp_clock_mode_generator.sv ----
// self-checking bench of the clock mode generator
// assumes the reference source model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module test_dsp_clock_mode_generator;
  localparam int unsigned LOCK = 20; // short lock wait
  logic        clock = 1'b0;         // system clock
  logic        reset = 1'b1;         // sync reset
  logic        psel = 1'b0;          // apb select
  logic        penable = 1'b0;       // apb access
  logic        pwrite = 1'b0;        // apb write
  logic [7:0]  paddr = 8'h00;        // apb address
  logic [31:0] pwdata = 32'h0;       // apb write data
  logic [31:0] prdata;               // apb read data
  logic        pready;               // apb ready
  logic        pslverr;              // apb error
  logic [2:0]  strap = 3'h0;         // straps 1,2,3
  logic [7:0]  half = 8'h0a;         // reference half period
  logic        ref_level;            // reference clock
  logic        osc, mclk, mtick, mco, locked;
  logic [2:0]  smap [4] = '{3'h0, 3'h5, 3'h7, 3'h3};
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  dspcmg_top #(.LOCK_CYCLES(LOCK)) dut
  (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_mode_strap_1(strap[2]), .clock_mode_strap_2(strap[1]), .clock_mode_strap_3(strap[0]),
    .reference_clock_input(ref_level), .oscillator_enable(osc), .machine_clock(mclk),
    .machine_tick(mtick), .machine_clock_output(mco), .pll_locked(locked)
  );
  dspcmg_ref_src src (.clock(clock), .half(half), .ref_level(ref_level));
  always #2.5 clock = ~clock;
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic complete_run;
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a hung handshake ends here instead of running for ever
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp);
    check_count++;
    if (got < exp - 2 || got > exp + 2)
    begin
      fails++;
      $display("Error %0t: tick count %0d expected %0d", $time, got, exp);
    end
  endtask
  // request held from setup until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(posedge clock);
    strap <= s;
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
  endtask
  // ticks over eight reference periods, after two periods to settle
  task automatic measure(input int e);
    int   n;
    int   m;
    logic p;
    n = 0;
    m = 0;
    repeat (4 * half) @(posedge clock);
    p = mclk;
    repeat (16 * half)
    begin
      @(posedge clock);
      n += int'(mtick === 1'b1);
      m += int'(mclk !== p);
      p = mclk;
    end
    chk_near(n, e);
    chk_near(m, e);
  endtask
  // output clock edges over 48 reference periods
  task automatic measure_out(input int e);
    int   n;
    logic p;
    n = 0;
    p = mco;
    repeat (96 * half)
    begin
      @(posedge clock);
      n += int'(mco !== p);
      p = mco;
    end
    chk_near(n, e);
  endtask
  function automatic int exp_ticks(input logic [2:0] s, input int q);
    if (s == 3'h5)
      return 4;
    if (s == 3'h0 || s == 3'h7)
      return 8;
    return 4 * q;
  endfunction
  task automatic pll_run(input logic [5:0] q, input logic [7:0] h, input logic flt);
    logic [31:0] rd;
    logic        err;
    half <= h;
    apb(1'b1, dspcmg_pkg::ADDR_PLL_MODE, {23'h0, 1'b1, 2'h0, q}, rd, err);
    repeat (3) @(posedge clock);
    chk(32'(locked), 32'h0);
    while (locked !== 1'b1)
      @(posedge clock);
    repeat (4 * h) @(posedge clock);
    apb(1'b0, dspcmg_pkg::ADDR_PLL_MODE, 32'h0, rd, err);
    chk(rd & 32'h773f, {17'h0, strap, 1'b0, flt, 2'h3, 2'h0, q});
    if (!flt)
      measure(exp_ticks(3'h3, int'(q)));
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic        err;
    logic [7:0]  a;
    void'($urandom(32'h5f48));
    for (int i = 0; i < 4; i++)
    begin
      do_reset(smap[i]);
      chk(32'(osc), 32'(smap[i] == 3'h0));
      chk(32'(locked), 32'(smap[i] != 3'h3));
      apb(1'b0, dspcmg_pkg::ADDR_PLL_MODE, 32'h0, rd, err);
      chk(rd & 32'h7000, {17'h0, smap[i], 12'h0});
      apb(1'b0, dspcmg_pkg::ADDR_BANK_SWITCH, 32'h0, rd, err);
      chk(rd & 32'h3, 32'h3);
      while (locked !== 1'b1)
        @(posedge clock);
      measure(exp_ticks(smap[i], 4));
    end
    do_reset(3'h0);
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, dspcmg_pkg::ADDR_BANK_SWITCH, {30'($urandom()), 2'(d)}, rd, err);
      apb(1'b0, dspcmg_pkg::ADDR_BANK_SWITCH, 32'h0, rd, err);
      chk(rd & 32'h3, 32'(d));
      measure(8);
      measure_out(48 / (d + 1));
    end
    a = 8'($urandom_range(63, 2) * 4);
    apb(1'b1, a, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    apb(1'b0, a, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, dspcmg_pkg::ADDR_BANK_SWITCH, 32'h0, rd, err);
    chk(rd & 32'h3, 32'h3);
    pll_run(6'h3c, 8'd20, 1'b0);
    pll_run(6'(4 * $urandom_range(15, 1)), 8'd20, 1'b0);
    pll_run(6'h0a, 8'd10, 1'b0);
    pll_run(6'h05, 8'd4, 1'b0);
    pll_run(6'h05, 8'd20, 1'b1);
    apb(1'b1, dspcmg_pkg::ADDR_PLL_MODE, 32'h100, rd, err);
    repeat (3) @(posedge clock);
    chk(32'(locked), 32'h1);
    apb(1'b0, dspcmg_pkg::ADDR_PLL_MODE, 32'h0, rd, err);
    chk(rd & 32'h3f, 32'h5);
    complete_run();
  end
endmodule
`default_nettype wire
